// *** common/des_regs.svh ***
// register offsets, field positions, reset values and timing counts of the scheduler
`ifndef DES_REGS_SVH
`define DES_REGS_SVH

// register offsets (byte addresses on the plain register port)
`define DES_OFS_CTRL 8'h00
`define DES_OFS_EFF 8'h04
`define DES_OFS_PRIO_ID 8'h08
`define DES_OFS_PRIO_MSK 8'h0C
`define DES_OFS_EMR1 8'h10
`define DES_OFS_REFI 8'h14
`define DES_OFS_STATUS 8'h18

// control register fields
`define DES_CTRL_MAP 0
`define DES_CTRL_GAP 1
`define DES_CTRL_SYNC 2
`define DES_CTRL_SREN 3

// efficiency register fields
`define DES_EFF_PBAP_LO 0
`define DES_EFF_PBAP_HI 7
`define DES_EFF_IDLE_LO 8
`define DES_EFF_IDLE_HI 11
`define DES_EFF_NREF_LO 12
`define DES_EFF_NREF_HI 15

// extended mode register 1: additive latency field
`define DES_EMR1_AL_LO 3
`define DES_EMR1_AL_HI 5

// reset values
`define DES_CTRL_RST 32'h0000_0000
`define DES_EFF_RST 32'h0000_0F00
`define DES_PRIO_ID_RST 16'h0000
`define DES_PRIO_MSK_RST 16'h0000
`define DES_EMR1_RST 16'h0000

// sizes
`define DES_MEM_WIDTH 16
`define DES_BURST_WORDS 4
`define DES_BURST_BYTES 8
`define DES_MAX_REF 4'h8
`define DES_IDLE_MAX 4'hF

// timing: times in ns, counts derived at the 40 ns clock period
`define DES_CLK_NS 40
`define DES_TRCD_NS 15
`define DES_TREFI_NS 7800
`define DES_TRCD_CYC (((`DES_TRCD_NS + `DES_CLK_NS - 1) / `DES_CLK_NS) < 1 ? 1 : \
  ((`DES_TRCD_NS + `DES_CLK_NS - 1) / `DES_CLK_NS))
`define DES_REFI_CYC (`DES_TREFI_NS / `DES_CLK_NS)

`endif

// *** common/des_pkg.sv ***
// types shared by the scheduler and its input stage
package des_pkg;

  // one crossbar request
  typedef struct packed {
    logic write;
    logic [15:0] master_id;
    logic [26:0] addr;
    logic [3:0] bursts;
  } des_req_t;

  // queued request with its precomputed priority flag
  typedef struct packed {
    logic prio;
    des_req_t req;
  } des_qent_t;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_REF, CMD_SRE, CMD_SRX
  } des_cmd_kind_t;

  // command towards the dram
  typedef struct packed {
    des_cmd_kind_t kind;
    logic [2:0] bank;
    logic [12:0] row;
    logic [9:0] col;
    logic auto_pre;
  } des_cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_ACT, ST_WAIT, ST_XFER, ST_PREA, ST_REF, ST_SR, ST_SRX
  } des_state_t;

endpackage

// *** hdl/des_ib.sv ***
// one-entry interface stage between the crossbar and the command buffer
module des_ib (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // mode: 0 one-cycle pass, 1 extra synchroniser cycle
  input wire logic sync_mode_i,
  // crossbar side
  input wire logic in_valid_i,
  input wire des_pkg::des_req_t in_req_i,
  output logic in_ready_o,
  // buffer side
  output logic out_valid_o,
  output des_pkg::des_req_t out_req_o,
  input wire logic out_ready_i
);

  logic full;
  logic aged;

  assign in_ready_o = !full;
  // the extra cycle costs throughput but is safe for unrelated clock ratios
  assign out_valid_o = full && (aged || !sync_mode_i);

  // hold one request until the buffer takes it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      full <= 1'b0;
      aged <= 1'b0;
      out_req_o <= '0;
    end else if (!full && in_valid_i) begin
      full <= 1'b1;
      aged <= 1'b0;
      out_req_o <= in_req_i;
    end else if (out_valid_o && out_ready_i) begin
      full <= 1'b0;
      aged <= 1'b0;
    end else if (full) begin
      aged <= 1'b1;
    end
  end

endmodule

// *** hdl/des_sched.sv ***
// dram command scheduler with auto-precharge, priority and postponed refresh
// How it works
// - address map select 0 interleaves banks using low address bits above the column.
// - a bank opens while other banks keep their rows open.
// - global auto-precharge turns every read into read with auto-precharge.
// - eight per-bank enables precharge only after a request's last burst.
// - global auto-precharge overrides the per-bank enables for reads.
// - additive latency of tRCD-1 lets the read follow the activate directly.
// - additive latency lives in the extended mode register 1 field.
// - master id matching priority id under mask raises request priority.
// - pending refreshes accumulate up to the programmed limit, at most eight.
// - buffers empty for idle count sends pending refreshes back to back.
// - idle threshold field is four bits, up to 15 cycles.
// - each refresh in a run rechecks that buffers are still empty.
// - pending count at limit makes one refresh urgent, taken ahead of queued requests once the executor is next idle.
// - with self-refresh enabled, pending refreshes wait until self-refresh entry.
// - each burst moves eight bytes as four 16-bit words.
// - requests enter through a stage with programmable synchroniser mode.
// - memory interface is 16 bits wide.
`include "des_regs.svh"
module des_sched #(
  parameter int REFI_CYC = `DES_REFI_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // crossbar requests
  input wire logic req_valid_i,
  input wire des_pkg::des_req_t req_i,
  output logic req_ready_o,
  // dram commands, one per cycle
  output des_pkg::des_cmd_t cmd_o,
  output logic [`DES_MEM_WIDTH-1:0] burst_words_o
);

  // registers
  logic [31:0] ctrl;
  logic [31:0] eff;
  logic [15:0] prio_id;
  logic [15:0] prio_msk;
  logic [15:0] emr1;
  logic [15:0] refi;

  // input stage and command buffer
  logic ib_valid;
  des_pkg::des_req_t ib_req;
  logic ib_ready;
  des_pkg::des_qent_t q [2];
  logic [1:0] qv;

  // executor
  des_pkg::des_state_t state;
  des_pkg::des_req_t cur;
  logic [2:0] cur_bank;
  logic [12:0] cur_row;
  logic [9:0] cur_col;
  logic [3:0] bursts_left;
  logic [2:0] wait_cnt;
  logic [7:0] bank_open;
  logic [12:0] open_row [8];

  // refresh bookkeeping
  logic [15:0] refi_cnt;
  logic [3:0] pending;
  logic [3:0] idle_cnt;
  logic urgent_sent;

  logic take;
  logic sel;
  logic buf_empty;
  logic idle_hit;
  logic [3:0] ref_limit;
  logic [2:0] al;
  logic [2:0] act_wait;
  logic refresh_now;
  logic interval_tick;
  logic row_ap;
  des_pkg::des_cmd_t next_cmd;

  assign al = emr1[`DES_EMR1_AL_HI:`DES_EMR1_AL_LO];
  // a limit of zero means refresh is not postponed at all
  assign ref_limit = (eff[`DES_EFF_NREF_HI:`DES_EFF_NREF_LO] == 4'h0) ? 4'h1 :
    (eff[`DES_EFF_NREF_HI:`DES_EFF_NREF_LO] > `DES_MAX_REF) ? `DES_MAX_REF :
    eff[`DES_EFF_NREF_HI:`DES_EFF_NREF_LO];
  // al of tRCD-1 or more removes the wait between activate and read
  assign act_wait = (al >= 3'(`DES_TRCD_CYC - 1)) ? 3'h0 :
    3'(`DES_TRCD_CYC - 1) - al;

  // programmable synchroniser stage in front of the buffer
  des_ib u_ib (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sync_mode_i(ctrl[`DES_CTRL_SYNC]),
    .in_valid_i(req_valid_i),
    .in_req_i(req_i),
    .in_ready_o(req_ready_o),
    .out_valid_o(ib_valid),
    .out_req_o(ib_req),
    .out_ready_i(ib_ready)
  );

  // register writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= `DES_CTRL_RST;
      eff <= `DES_EFF_RST;
      prio_id <= `DES_PRIO_ID_RST;
      prio_msk <= `DES_PRIO_MSK_RST;
      emr1 <= `DES_EMR1_RST;
      refi <= 16'(REFI_CYC);
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `DES_OFS_CTRL: ctrl <= {28'h0, reg_wdata_i[3:0]};
        `DES_OFS_EFF: eff <= {16'h0, reg_wdata_i[15:0]};
        `DES_OFS_PRIO_ID: prio_id <= reg_wdata_i[15:0];
        `DES_OFS_PRIO_MSK: prio_msk <= reg_wdata_i[15:0];
        `DES_OFS_EMR1: emr1 <= reg_wdata_i[15:0];
        `DES_OFS_REFI: refi <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `DES_OFS_CTRL: reg_rdata_o <= ctrl;
        `DES_OFS_EFF: reg_rdata_o <= eff;
        `DES_OFS_PRIO_ID: reg_rdata_o <= {16'h0, prio_id};
        `DES_OFS_PRIO_MSK: reg_rdata_o <= {16'h0, prio_msk};
        `DES_OFS_EMR1: reg_rdata_o <= {16'h0, emr1};
        `DES_OFS_REFI: reg_rdata_o <= {16'h0, refi};
        `DES_OFS_STATUS: reg_rdata_o <= {12'h0, 4'(state), bank_open, pending, 1'b0, qv,
          state == des_pkg::ST_SR};
        default: reg_rdata_o <= 32'h0;
      endcase
    end
  end

  // buffer selection: the second entry may pass only a normal entry of another master
  assign sel = qv[1] && q[1].prio && !q[0].prio &&
    (q[1].req.master_id != q[0].req.master_id);
  assign take = (state == des_pkg::ST_IDLE) && qv[0] && !refresh_now &&
    !(ctrl[`DES_CTRL_SREN] && pending != 4'h0 && 1'b0);
  assign ib_ready = !qv[1] || take;
  // a request still ageing in the stage counts as traffic, so idle cannot be misread
  assign buf_empty = (qv == 2'b00) && req_ready_o;

  // two-entry command buffer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      qv <= 2'b00;
      q[0] <= '0;
      q[1] <= '0;
    end else begin
      logic [1:0] v;
      des_pkg::des_qent_t e0;
      des_pkg::des_qent_t nw;
      v = qv;
      e0 = q[0];
      nw.req = ib_req;
      nw.prio = ((ib_req.master_id ^ prio_id) & prio_msk) == 16'h0;
      if (take) begin
        if (!sel) begin
          e0 = q[1];
        end
        v = {1'b0, qv[1]};
      end
      if (ib_valid && ib_ready) begin
        if (!v[0]) begin
          e0 = nw;
          v[0] = 1'b1;
        end else begin
          q[1] <= nw;
          v[1] = 1'b1;
        end
      end
      q[0] <= e0;
      qv <= v;
    end
  end

  // refresh interval timer
  assign interval_tick = (refi_cnt == 16'h0);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      refi_cnt <= 16'(REFI_CYC);
    end else if (interval_tick) begin
      refi_cnt <= refi;
    end else begin
      refi_cnt <= refi_cnt - 16'h1;
    end
  end

  // pending count: issue decrements, expiry increments up to the limit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending <= 4'h0;
    end else begin
      logic [3:0] p;
      p = pending;
      // counting the refresh as it is chosen keeps a run from sending one too many
      if (next_cmd.kind == des_pkg::CMD_REF && p != 4'h0) begin
        p = p - 4'h1;
      end
      if (interval_tick && p < ref_limit) begin
        p = p + 4'h1;
      end
      pending <= p;
    end
  end

  // idle watch on the command buffer and the input stage
  assign idle_hit = (idle_cnt >= eff[`DES_EFF_IDLE_HI:`DES_EFF_IDLE_LO]);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_cnt <= 4'h0;
    end else if (!buf_empty || pending == 4'h0) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != `DES_IDLE_MAX) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // refresh when idle long enough, or one urgent refresh at the limit;
  // with self-refresh enabled everything is held for self-refresh entry
  assign refresh_now = !ctrl[`DES_CTRL_SREN] && pending != 4'h0 &&
    ((buf_empty && idle_hit) || (pending >= ref_limit));

  // address split: mode 0 puts bank bits just above the page
  assign cur_col = cur.addr[10:1];
  assign cur_bank = ctrl[`DES_CTRL_MAP] ? cur.addr[26:24] : cur.addr[13:11];
  assign cur_row = ctrl[`DES_CTRL_MAP] ? cur.addr[23:11] : cur.addr[26:14];
  assign row_ap = (!cur.write && ctrl[`DES_CTRL_GAP]) ||
    (eff[`DES_EFF_PBAP_LO + cur_bank] && bursts_left == 4'h1);

  // next command
  always_comb begin
    next_cmd = '0;
    next_cmd.kind = des_pkg::CMD_NOP;
    next_cmd.bank = cur_bank;
    next_cmd.row = cur_row;
    next_cmd.col = cur_col;
    unique case (state)
      des_pkg::ST_PRE: next_cmd.kind = des_pkg::CMD_PRE;
      // the decode cycle after a pop only inspects the bank and sends nothing
      des_pkg::ST_ACT: next_cmd.kind = (wait_cnt == 3'h0) ? des_pkg::CMD_ACT : des_pkg::CMD_NOP;
      des_pkg::ST_XFER: begin
        next_cmd.kind = cur.write ? des_pkg::CMD_WR : des_pkg::CMD_RD;
        next_cmd.auto_pre = row_ap;
      end
      des_pkg::ST_PREA: next_cmd.kind = des_pkg::CMD_PREA;
      des_pkg::ST_REF: next_cmd.kind = (pending != 4'h0) ? des_pkg::CMD_REF : des_pkg::CMD_NOP;
      des_pkg::ST_SR: begin
        // held refreshes drain once inside self-refresh
        next_cmd.kind = (pending != 4'h0) ? des_pkg::CMD_REF : des_pkg::CMD_NOP;
      end
      des_pkg::ST_SRX: next_cmd.kind = des_pkg::CMD_SRX;
      default: next_cmd.kind = des_pkg::CMD_NOP;
    endcase
    if (state == des_pkg::ST_IDLE && ctrl[`DES_CTRL_SREN] && buf_empty &&
      bank_open == 8'h0) begin
      next_cmd.kind = des_pkg::CMD_SRE;
    end
  end

  // command and burst word count come from flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_o <= '0;
      burst_words_o <= '0;
    end else begin
      cmd_o <= next_cmd;
      burst_words_o <= (next_cmd.kind == des_pkg::CMD_RD || next_cmd.kind == des_pkg::CMD_WR) ?
        16'(`DES_BURST_WORDS) : 16'h0;
    end
  end

  // executor state machine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= des_pkg::ST_IDLE;
      cur <= '0;
      bursts_left <= 4'h0;
      wait_cnt <= 3'h0;
      urgent_sent <= 1'b0;
    end else begin
      unique case (state)
        des_pkg::ST_IDLE: begin
          if (next_cmd.kind == des_pkg::CMD_SRE) begin
            state <= des_pkg::ST_SR;
          end else if (refresh_now) begin
            state <= (bank_open != 8'h0) ? des_pkg::ST_PREA : des_pkg::ST_REF;
          end else if (take) begin
            cur <= sel ? q[1].req : q[0].req;
            // requests below one burst still use a whole burst
            bursts_left <= ((sel ? q[1].req.bursts : q[0].req.bursts) == 4'h0) ? 4'h1 :
              (sel ? q[1].req.bursts : q[0].req.bursts);
            state <= des_pkg::ST_ACT;
            wait_cnt <= 3'h1;
          end
        end
        des_pkg::ST_ACT: begin
          // wait_cnt 1 marks the decode cycle right after the buffer pop
          if (wait_cnt != 3'h0) begin
            wait_cnt <= 3'h0;
            if (bank_open[cur_bank] && open_row[cur_bank] == cur_row) begin
              state <= des_pkg::ST_XFER;
            end else if (bank_open[cur_bank]) begin
              state <= des_pkg::ST_PRE;
            end
          end else begin
            // other open banks are left alone
            wait_cnt <= act_wait;
            state <= (act_wait == 3'h0) ? des_pkg::ST_XFER : des_pkg::ST_WAIT;
          end
        end
        des_pkg::ST_PRE: state <= des_pkg::ST_ACT;
        des_pkg::ST_WAIT: begin
          wait_cnt <= wait_cnt - 3'h1;
          if (wait_cnt == 3'h1) begin
            state <= des_pkg::ST_XFER;
          end
        end
        des_pkg::ST_XFER: begin
          bursts_left <= bursts_left - 4'h1;
          cur.addr <= cur.addr + 27'(`DES_BURST_BYTES);
          if (bursts_left == 4'h1) begin
            state <= des_pkg::ST_IDLE;
          end else if (row_ap) begin
            state <= des_pkg::ST_ACT; // row was closed by the burst
          end
        end
        des_pkg::ST_PREA: state <= des_pkg::ST_REF;
        des_pkg::ST_REF: begin
          // an urgent refresh sends just one, then waits for idle again
          urgent_sent <= !buf_empty || !idle_hit;
          if (pending <= 4'h1 || !buf_empty || !idle_hit) begin
            state <= des_pkg::ST_IDLE;
          end
        end
        des_pkg::ST_SR: begin
          if ((!ctrl[`DES_CTRL_SREN] || !buf_empty) && pending == 4'h0) begin
            state <= des_pkg::ST_SRX;
          end
        end
        des_pkg::ST_SRX: state <= des_pkg::ST_IDLE;
        default: state <= des_pkg::ST_IDLE;
      endcase
    end
  end

  // per-bank open row tracking
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bank
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          bank_open[b] <= 1'b0;
          open_row[b] <= 13'h0;
        end else if (next_cmd.kind == des_pkg::CMD_PREA) begin
          bank_open[b] <= 1'b0;
        end else if (next_cmd.bank == 3'(b)) begin
          if (next_cmd.kind == des_pkg::CMD_ACT) begin
            bank_open[b] <= 1'b1;
            open_row[b] <= next_cmd.row;
          end else if (next_cmd.kind == des_pkg::CMD_PRE || next_cmd.auto_pre) begin
            bank_open[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

// *** testbench/des_sched_checker.sv ***
// concurrent checks on the scheduler's ports, bound into the scheduler module
`include "des_regs.svh"
module des_sched_checker #(
  parameter int REFI_CYC = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // crossbar requests
  input wire logic req_valid_i,
  input wire des_pkg::des_req_t req_i,
  input wire logic req_ready_o,
  // dram commands
  input wire des_pkg::des_cmd_t cmd_o,
  input wire logic [`DES_MEM_WIDTH-1:0] burst_words_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gap;
  logic sren;
  logic in_sr;
  logic xfer;
  logic [7:0] pbap;
  logic [7:0] open_bank;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  assign xfer = cmd_o.kind inside {des_pkg::CMD_RD, des_pkg::CMD_WR};
  // mirror of the fields that steer auto-precharge and self-refresh
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap <= 1'b0;
      sren <= 1'b0;
      pbap <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == `DES_OFS_CTRL) begin
      gap <= reg_wdata_i[`DES_CTRL_GAP];
      sren <= reg_wdata_i[`DES_CTRL_SREN];
    end else if (reg_wr_i && reg_addr_i == `DES_OFS_EFF) begin
      pbap <= reg_wdata_i[`DES_EFF_PBAP_HI:`DES_EFF_PBAP_LO];
    end
  end
  // bank and self-refresh state as implied by the command stream
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      open_bank <= 8'h00;
      in_sr <= 1'b0;
    end else begin
      case (cmd_o.kind)
        des_pkg::CMD_ACT: open_bank[cmd_o.bank] <= 1'b1;
        des_pkg::CMD_PRE: open_bank[cmd_o.bank] <= 1'b0;
        des_pkg::CMD_PREA: open_bank <= 8'h00;
        des_pkg::CMD_SRE: in_sr <= 1'b1;
        des_pkg::CMD_SRX: in_sr <= 1'b0;
        default: begin
          if (xfer && cmd_o.auto_pre) open_bank[cmd_o.bank] <= 1'b0;
        end
      endcase
    end
  end
  property p_burst_len;
    xfer |-> burst_words_o == 16'h0004;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst word count wrong");
  property p_burst_zero;
    !xfer |-> burst_words_o == 16'h0000;
  endproperty
  a_burst_zero: assert property (p_burst_zero) else $error("words outside burst");
  property p_rd_open;
    xfer |-> open_bank[cmd_o.bank];
  endproperty
  a_rd_open: assert property (p_rd_open) else $error("transfer to closed bank");
  property p_ref_closed;
    cmd_o.kind == des_pkg::CMD_REF |-> open_bank == 8'h00;
  endproperty
  a_ref_closed: assert property (p_ref_closed) else $error("refresh with open row");
  property p_gap_ap;
    gap && cmd_o.kind == des_pkg::CMD_RD |-> cmd_o.auto_pre;
  endproperty
  a_gap_ap: assert property (p_gap_ap) else $error("read kept row open");
  property p_pbap_ap;
    (cmd_o.kind == des_pkg::CMD_WR || (cmd_o.kind == des_pkg::CMD_RD && !gap))
      && !pbap[cmd_o.bank] |-> !cmd_o.auto_pre;
  endproperty
  a_pbap_ap: assert property (p_pbap_ap) else $error("precharge on disabled bank");
  property p_sr_ref;
    cmd_o.kind == des_pkg::CMD_REF && sren && $past(sren, 3) |-> in_sr;
  endproperty
  a_sr_ref: assert property (p_sr_ref) else $error("refresh before self-refresh");
  property p_sr_quiet;
    in_sr |-> !xfer && cmd_o.kind != des_pkg::CMD_ACT;
  endproperty
  a_sr_quiet: assert property (p_sr_quiet) else $error("traffic in self-refresh");
  c_rd_ap: cover property (cmd_o.kind == des_pkg::CMD_RD && cmd_o.auto_pre);
  c_ref: cover property (cmd_o.kind == des_pkg::CMD_REF);
  c_sre: cover property (cmd_o.kind == des_pkg::CMD_SRE);
endmodule
bind des_sched des_sched_checker #(.REFI_CYC(REFI_CYC)) u_des_sched_checker (.*);

// *** testbench/des_dram_model.sv ***
// behavioural dram device watching the scheduler's command stream
`include "des_regs.svh"
module des_dram_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // command stream from the controller
  input wire des_pkg::des_cmd_t cmd_i,
  input wire logic [`DES_MEM_WIDTH-1:0] burst_words_i,
  // activity counts for the bench
  output logic [31:0] ref_count_o,
  output logic [31:0] sre_count_o,
  output logic [31:0] fault_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] row_open;
  // rows per bank; a burst to a closed bank or a refresh over open rows is a fault
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_open <= 8'h00;
      ref_count_o <= 32'h0;
      sre_count_o <= 32'h0;
      fault_count_o <= 32'h0;
    end else begin
      case (cmd_i.kind)
        des_pkg::CMD_ACT: row_open[cmd_i.bank] <= 1'b1;
        des_pkg::CMD_PRE: row_open[cmd_i.bank] <= 1'b0;
        des_pkg::CMD_PREA: row_open <= 8'h00;
        des_pkg::CMD_SRE: sre_count_o <= sre_count_o + 32'h1;
        des_pkg::CMD_REF: begin
          ref_count_o <= ref_count_o + 32'h1;
          if (row_open != 8'h00) fault_count_o <= fault_count_o + 32'h1;
        end
        des_pkg::CMD_RD, des_pkg::CMD_WR: begin
          if (cmd_i.auto_pre) row_open[cmd_i.bank] <= 1'b0;
          if (!row_open[cmd_i.bank] || burst_words_i != 16'h0004) begin
            fault_count_o <= fault_count_o + 32'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the dram command scheduler
`include "des_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic rst_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic req_valid_i;
  des_pkg::des_req_t req_i;
  logic req_ready_o;
  des_pkg::des_cmd_t cmd_o;
  logic [`DES_MEM_WIDTH-1:0] burst_words_o;
  logic [31:0] ref_count;
  logic [31:0] sre_count;
  logic [31:0] fault_count;
  logic [31:0] lfsr;
  logic [31:0] snap;
  logic [7:0] pbap;
  logic gap;
  logic rd_taken;
  logic [31:0] reg_q[$];
  des_pkg::des_cmd_t cmd_q[$];
  int num_errors;
  int comparisons;
  des_sched #(.REFI_CYC(20)) u_des_sched (.*);
  des_dram_model u_des_dram_model (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_o),
    .burst_words_i(burst_words_o), .ref_count_o(ref_count), .sre_count_o(sre_count),
    .fault_count_o(fault_count));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic note(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    note(got === exp, "register read data");
  endtask
  task automatic cmp_cmd(input des_pkg::des_cmd_t got, input des_pkg::des_cmd_t exp);
    note(got.kind === exp.kind && got.bank === exp.bank && got.col === exp.col
      && got.auto_pre === exp.auto_pre, "transfer command");
  endtask
  // strobes stay up across back-to-back accesses; bus_idle drops them all
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_rd_i <= 1'b0;
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    reg_q.push_back(e);
    @(posedge clk_i);
  endtask
  task automatic bus_idle();
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    req_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // notes one transfer per burst, then holds the request until it is taken
  task automatic send_req(input logic wr, input logic [26:0] a, input logic [3:0] n);
    des_pkg::des_cmd_t e;
    logic [26:0] b;
    logic ok;
    int cnt;
    cnt = (n == 4'h0) ? 1 : int'(n);
    for (int k = 0; k < cnt; k++) begin
      b = a + 27'(8 * k);
      e = '0;
      e.kind = wr ? des_pkg::CMD_WR : des_pkg::CMD_RD;
      e.bank = b[13:11];
      e.col = b[10:1];
      e.auto_pre = (!wr && gap) || (pbap[b[13:11]] && k == cnt - 1);
      cmd_q.push_back(e);
    end
    req_i <= '{write: wr, master_id: 16'h00C0, addr: a, bursts: n};
    req_valid_i <= 1'b1;
    ok = 1'b0;
    for (cnt = 0; cnt < 50 && !ok; cnt++) begin
      @(negedge clk_i);
      ok = (req_ready_o === 1'b1);
      @(posedge clk_i);
    end
    if (!ok) begin
      note(1'b0, "request never taken");
      stop_test();
    end
  endtask
  task automatic rand_req();
    lfsr = next_rand(lfsr);
    send_req(lfsr[0], {lfsr[26:5], 5'h00}, {2'b00, lfsr[8:7]});
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 3000 && cmd_q.size() != 0; k++) @(posedge clk_i);
    if (cmd_q.size() != 0) begin
      note(1'b0, "transfers outstanding");
      stop_test();
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // results are matched against the oldest note as they appear
  always @(posedge clk_i) begin
    if (rd_taken) cmp_reg(reg_rdata_o, reg_q.pop_front());
    rd_taken <= reg_rd_i && !rst_i;
    if (!rst_i && (cmd_o.kind === des_pkg::CMD_RD || cmd_o.kind === des_pkg::CMD_WR)) begin
      if (cmd_q.size() == 0) note(1'b0, "unexpected transfer");
      else cmp_cmd(cmd_o, cmd_q.pop_front());
    end
  end
  initial begin
    {rst_i, rd_taken, gap, pbap, lfsr} = {1'b1, 1'b0, 1'b0, 8'h00, 32'hA506};
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, req_valid_i} = '0;
    req_i = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, an unmapped place, latency and priority fields
    reg_read(`DES_OFS_CTRL, `DES_CTRL_RST);
    reg_read(`DES_OFS_EFF, `DES_EFF_RST);
    reg_read(`DES_OFS_PRIO_MSK, 32'(`DES_PRIO_MSK_RST));
    reg_write(8'h1C, 32'hFFFF_FFFF);
    reg_read(8'h1C, 32'h0000_0000);
    reg_write(`DES_OFS_EMR1, 32'((`DES_TRCD_CYC - 1) << `DES_EMR1_AL_LO));
    reg_read(`DES_OFS_EMR1, 32'((`DES_TRCD_CYC - 1) << `DES_EMR1_AL_LO));
    reg_write(`DES_OFS_PRIO_ID, 32'h0000_00C0);
    reg_write(`DES_OFS_PRIO_MSK, 32'h0000_FFFF);
    reg_read(`DES_OFS_PRIO_MSK, 32'h0000_FFFF);
    // global auto-precharge, back-to-back random traffic
    gap = 1'b1;
    reg_write(`DES_OFS_CTRL, 32'h0000_0002);
    bus_idle();
    repeat (8) rand_req();
    bus_idle();
    drain();
    // per-bank auto-precharge on a random bank set, idle limit at its top
    lfsr = next_rand(lfsr);
    gap = 1'b0;
    pbap = lfsr[7:0];
    reg_write(`DES_OFS_CTRL, 32'h0000_0000);
    reg_write(`DES_OFS_EFF, {16'h0000, 4'h8, `DES_IDLE_MAX, lfsr[7:0]});
    reg_read(`DES_OFS_EFF, {16'h0000, 4'h8, `DES_IDLE_MAX, lfsr[7:0]});
    bus_idle();
    repeat (12) rand_req();
    bus_idle();
    drain();
    // idle bus: postponed refreshes go out once the buffers stay empty
    reg_write(`DES_OFS_REFI, 32'h0000_0014);
    bus_idle();
    snap = ref_count;
    repeat (300) @(posedge clk_i);
    note(ref_count - snap >= 32'hA && ref_count - snap <= 32'h11, "refresh count");
    // self-refresh holds refreshes until entry, then clearing the enable wakes it before traffic
    snap = sre_count;
    reg_write(`DES_OFS_CTRL, 32'h0000_0008);
    bus_idle();
    repeat (200) @(posedge clk_i);
    note(sre_count > snap, "self-refresh entry");
    reg_write(`DES_OFS_CTRL, 32'h0000_0004);
    bus_idle();
    repeat (30) @(posedge clk_i);
    send_req(1'b0, 27'h000_0800, 4'h2);
    bus_idle();
    drain();
    note(fault_count === 32'h0, "device fault seen");
    stop_test();
  end
endmodule
